// *** core/window_line_regs.sv ***
/*
 window and line-count register bank with run control and frame walker.
 assumes a byte register port on mclk and async sync pins.
*/
`timescale 1ns/1ps
module window_line_regs
	import window_regs_pkg::*;
#(
	parameter logic [3:0] VERSION = 4'h1  // arbitrary version value
) (
	input  wire logic        mclk,                // pixel clock, 25 MHz
	input  wire logic        rstn,                // async reset, low
	input  wire logic [7:0]  addr,                // direct register address
	input  wire logic [7:0]  wr_data,             // write data
	input  wire logic        wr_en,               // write strobe
	input  wire logic        rd_en,               // read strobe
	output logic      [7:0]  rd_data,             // read data, next cycle
	input  wire logic        vertical_sync_in,    // frame pin
	input  wire logic        horizontal_sync_in,  // line pin
	output logic             run_active,          // run bit
	output logic             compress_select,     // 1 compress, 0 expand
	output logic      [7:0]  setup_one,           // setup byte one
	output logic      [7:0]  setup_two,           // setup byte two
	output logic      [7:0]  io_mode,             // operating mode byte
	output logic      [12:0] horiz_offset_pixels, // window x offset
	output logic      [15:0] active_pixel_count,  // window width
	output logic      [1:0]  pixel_ratio,         // pixel to codec ratio
	output logic             pixel_out_bus_on_codec_clk,  // output bus clock pick
	output logic             line_take,           // line processed pulse
	output logic             frame_busy,          // frame in progress
	output logic             frame_done           // frame end pulse
);
	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic        go;        // run control
		logic [7:0]  mode;      // operating mode
		logic [7:0]  ptr;       // indirect pointer
		logic [7:0]  setup1;    // setup one
		logic [7:0]  setup2;    // setup two
		logic [12:0] hoff;      // horizontal offset
		logic [15:0] apix;      // active pixels
		logic [12:0] voff;      // vertical offset
		logic [15:0] aline;     // active line count
		logic [15:0] proc;      // processed lines
		logic        counted;   // a frame has reported
		logic [7:0]  rdata;     // read data
		logic [1:0]  ratio;     // clock ratio
		logic        on_codec;  // output bus on codec clock
	} bank_s;

	localparam bank_s BANK_RST = '{
		go:       1'b0,
		mode:     MODE_RST,
		ptr:      8'h00,
		setup1:   SETUP1_RST,
		setup2:   SETUP2_RST,
		hoff:     HOFF_RST,
		apix:     APIX_RST,
		voff:     VOFF_RST,
		aline:    ALINE_RST,
		proc:     ALINE_RST,
		counted:  1'b0,
		rdata:    8'h00,
		ratio:    RATIO_HALF,
		on_codec: 1'b0
	};

	bank_s q;  // state
	bank_s n;  // next state

	logic [1:0]  sync_rise;  // edges: bit1 vsync, bit0 hsync
	logic [1:0]  sync_fall;  // falling edges
	logic [16:0] target;     // logical line count
	logic        lc_take;    // walker take pulse
	logic        lc_busy;    // walker busy
	logic        lc_done;    // walker done pulse
	logic [16:0] lc_lines;   // walker result
	logic        ind_wr;     // write to indirect space
	logic [2:0]  fmt;        // image format code
	logic [1:0]  base_ratio; // ratio without halving
	logic        dbl;        // codec clock halved

	////////////////////////////////////////////////////////////////////////////////
	// indirect read mux

	// pointer selects; reserved and unmapped read zero
	function automatic logic [7:0] ind_read(input bank_s s);
		logic [7:0] v;
		v = 8'h00;
		case (s.ptr)
			IND_SETUP1:   v = s.setup1;
			IND_SETUP2:   v = s.setup2;
			IND_HOFF_LO:  v = s.hoff[7:0];
			IND_HOFF_HI:  v = {3'h0, s.hoff[12:8]};
			IND_APIX_LO:  v = s.apix[7:0];
			IND_APIX_HI:  v = s.apix[15:8];
			IND_VOFF_LO:  v = s.voff[7:0];
			IND_VOFF_HI:  v = {3'h0, s.voff[12:8]};
			IND_ALINE_LO: v = s.aline[7:0];
			IND_ALINE_HI: v = s.aline[15:8];
			IND_PROC_LO:  v = s.proc[7:0];
			IND_PROC_HI:  v = s.proc[15:8];
			default:      v = 8'h00;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// data register writes land at the pointed register
	assign ind_wr = wr_en && (addr == DIR_DATA);

	// all-ones literal stands for 65536 lines
	assign target = (q.aline == ALINE_MAXLIT) ? MAX_LINES : {1'b0, q.aline};

	assign fmt = q.mode[FMT_MSB:FMT_LSB];

	// base ratio from format; whole design runs on the pixel clock,
	// the codec clock plant reads pixel_ratio
	always_comb begin
		case (fmt)
			FMT_444: base_ratio = RATIO_QUARTER;
			FMT_400: base_ratio = RATIO_ONE;
			default: base_ratio = RATIO_HALF;
		endcase
	end

	// half width offers a second ratio except mono and 2x2
	assign dbl = q.setup1[HALFW_BIT] && q.setup1[CLOCK_RATIO_SELECT_BIT]
		&& (fmt != FMT_400) && (fmt != FMT_411V);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		n       = q;
		n.rdata = 8'h00;  // data stand for one cycle only

		// clock ratio, doubled when the codec clock is slowed
		if (dbl) begin
			n.ratio = (base_ratio == RATIO_QUARTER) ? RATIO_HALF : RATIO_ONE;
		end else begin
			n.ratio = base_ratio;
		end
		n.on_codec = (n.ratio == RATIO_ONE);

		// frame result; compression only
		if (lc_done && q.mode[COMPRESS_BIT]) begin
			n.proc    = lc_lines[15:0];
			n.counted = 1'b1;
		end
		// single frame drops the run bit when done
		if (lc_done && !q.setup1[SEQ_BIT]) begin
			n.go = 1'b0;
		end

		// direct writes; a software run write wins over the hardware clear
		if (wr_en) begin
			case (addr)
				DIR_RUN:  n.go   = wr_data[RUN_BIT];
				DIR_MODE: n.mode = wr_data;
				DIR_PTR:  n.ptr  = wr_data;
				default:  n.go   = n.go;              // data and unmapped
			endcase
		end

		// indirect writes; counter is read-only
		if (ind_wr) begin
			case (q.ptr)
				IND_SETUP1:   n.setup1     = wr_data;
				IND_SETUP2:   n.setup2     = wr_data & SETUP2_MASK;
				IND_HOFF_LO:  n.hoff[7:0]  = wr_data;
				IND_HOFF_HI:  n.hoff[12:8] = wr_data[4:0];
				IND_APIX_LO:  n.apix[7:0]  = wr_data;
				IND_APIX_HI:  n.apix[15:8] = wr_data;
				IND_VOFF_LO:  n.voff[7:0]  = wr_data;
				IND_VOFF_HI:  n.voff[12:8] = wr_data[4:0];
				IND_ALINE_LO: begin
					n.aline[7:0] = wr_data;
					if (!n.counted) begin
						n.proc[7:0] = wr_data;  // counter starts at count
					end
				end
				IND_ALINE_HI: begin
					n.aline[15:8] = wr_data;
					if (!n.counted) begin
						n.proc[15:8] = wr_data;
					end
				end
				default: n.ptr = n.ptr;  // read-only or unmapped
			endcase
		end

		// reads see state before this cycle's write
		if (rd_en) begin
			case (addr)
				DIR_RUN:  n.rdata = {VERSION, 3'h0, q.go};
				DIR_MODE: n.rdata = q.mode;
				DIR_PTR:  n.rdata = q.ptr;
				DIR_DATA: n.rdata = ind_read(q);
				default:  n.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			q <= BANK_RST;
		end else begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// submodules

	// pins resynchronised before any use
	pin_sync u_sync (
		.mclk (mclk),
		.rstn (rstn),
		.pins ({vertical_sync_in, horizontal_sync_in}),
		.rise (sync_rise),
		.fall (sync_fall)
	);

	// expansion walks the window too but leaves the processed counter alone
	line_counter u_walk (
		.mclk        (mclk),
		.rstn        (rstn),
		.vs_rise     (sync_rise[1]),
		.vs_fall     (sync_fall[1]),
		.hs_rise     (sync_rise[0]),
		.arm         (q.go),
		.half_height_scale_offset (q.voff),
		.target      (target),
		.half_height (q.setup1[HALFH_BIT]),  // relies on even count
		.line_take   (lc_take),
		.busy        (lc_busy),
		.done        (lc_done),
		.lines_done  (lc_lines)
	);

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign rd_data             = q.rdata;
	assign run_active          = q.go;
	assign compress_select     = q.mode[COMPRESS_BIT];
	assign setup_one           = q.setup1;
	assign setup_two           = q.setup2;
	assign io_mode             = q.mode;
	assign horiz_offset_pixels = q.hoff;
	assign active_pixel_count  = q.apix;
	assign pixel_ratio         = q.ratio;
	assign pixel_out_bus_on_codec_clk  = q.on_codec;
	assign line_take           = lc_take;
	assign frame_busy          = lc_busy;
	assign frame_done          = lc_done;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	sequence seq_point_voff_hi;
		wr_en && addr == DIR_PTR && wr_data == IND_VOFF_HI;
	endsequence
	sequence seq_data_write;
		wr_en && addr == DIR_DATA;
	endsequence

	chk_ptr_write: assert property (@(posedge mclk) disable iff (!rstn)
		(wr_en && addr == DIR_PTR) |=> q.ptr == $past(wr_data))
		else $error("pointer not written");
	chk_voff_route: assert property (@(posedge mclk) disable iff (!rstn)
		seq_point_voff_hi ##1 seq_data_write |=> q.voff[12:8] == $past(wr_data[4:0]))
		else $error("offset high bits not routed");
	chk_aline_route: assert property (@(posedge mclk) disable iff (!rstn)
		(ind_wr && q.ptr == IND_ALINE_HI) |=> q.aline[15:8] == $past(wr_data))
		else $error("line count high byte not routed");
	chk_version_read: assert property (@(posedge mclk) disable iff (!rstn)
		(rd_en && addr == DIR_RUN) |=> rd_data == {VERSION, 3'h0, $past(q.go)})
		else $error("run register read wrong");
	chk_literal_max: assert property (@(posedge mclk) disable iff (!rstn)
		q.aline == ALINE_MAXLIT |-> target == MAX_LINES)
		else $error("all-ones count not 65536");
	chk_nol_capture: assert property (@(posedge mclk) disable iff (!rstn)
		(lc_done && q.mode[COMPRESS_BIT]) |=> q.proc == $past(lc_lines[15:0]))
		else $error("processed count not captured");
	chk_nol_wrap: assert property (@(posedge mclk) disable iff (!rstn)
		(lc_done && q.mode[COMPRESS_BIT] && lc_lines == MAX_LINES) |=> q.proc == 16'h0000)
		else $error("65536 lines not read as zero");
	chk_single_stop: assert property (@(posedge mclk) disable iff (!rstn)
		(lc_done && !q.setup1[SEQ_BIT] && !(wr_en && addr == DIR_RUN)) |=> !q.go)
		else $error("single frame left run set");
	chk_clock_ratio_select_double: assert property (@(posedge mclk) disable iff (!rstn)
		(dbl && fmt == FMT_444) [*2] |-> q.ratio == RATIO_HALF)
		else $error("slow codec clock ratio wrong");
	chk_codec_clk: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(pixel_out_bus_on_codec_clk) |-> $past(fmt == FMT_400 || dbl && base_ratio == RATIO_HALF))
		else $error("output bus moved without ratio one");
endmodule

// *** pkg/window_regs_pkg.sv ***
/*
 window and line-count register constants: offsets, fields, reset values.
 assumes one clock (the pixel clock) and a plain byte-wide register port.
*/
// How it works
// - 13-bit vertical offset, high bits at 0x07
// - 16-bit active line count, resets 0x00F0
// - count 0xFFFF means 65536 lines
// - nonzero count exact; zero runs to vsync fall
// - trailing partial strip is discarded
// - read-only processed counter, starts at count
// - sequential reads give previous frame's lines
// - stop at 65536 lines, which reads zero
// - pixel and codec clocks in format ratio
// - ratio one: pixel output on codec clock
// - half-width offers two ratios via select, except mono and 2x2
// - ratio select halves codec clock rate
// - single frame then idle, or sequential
// - compress select resets to compression
// - half-height drops even window lines
package window_regs_pkg;
	// direct register offsets
	localparam logic [7:0] DIR_RUN      = 8'h00;
	localparam logic [7:0] DIR_MODE     = 8'h01;
	localparam logic [7:0] DIR_PTR      = 8'h02;
	localparam logic [7:0] DIR_DATA     = 8'h03;
	// indirect pointers
	localparam logic [7:0] IND_SETUP1   = 8'h00;
	localparam logic [7:0] IND_SETUP2   = 8'h01;
	localparam logic [7:0] IND_HOFF_LO  = 8'h02;
	localparam logic [7:0] IND_HOFF_HI  = 8'h03;
	localparam logic [7:0] IND_APIX_LO  = 8'h04;
	localparam logic [7:0] IND_APIX_HI  = 8'h05;
	localparam logic [7:0] IND_VOFF_LO  = 8'h06;
	localparam logic [7:0] IND_VOFF_HI  = 8'h07;
	localparam logic [7:0] IND_ALINE_LO = 8'h08;
	localparam logic [7:0] IND_ALINE_HI = 8'h09;
	localparam logic [7:0] IND_PROC_LO  = 8'h0A;
	localparam logic [7:0] IND_PROC_HI  = 8'h0B;
	// field positions
	localparam int RUN_BIT      = 0;
	localparam int SEQ_BIT      = 0;
	localparam int HALFW_BIT    = 5;
	localparam int HALFH_BIT    = 6;
	localparam int CLOCK_RATIO_SELECT_BIT     = 7;
	localparam int COMPRESS_BIT = 7;
	localparam int FMT_LSB      = 0;
	localparam int FMT_MSB      = 2;
	// reset values and writable masks
	localparam logic [7:0]  MODE_RST    = 8'h80;
	localparam logic [7:0]  SETUP1_RST  = 8'h01;
	localparam logic [7:0]  SETUP2_RST  = 8'h00;
	localparam logic [7:0]  SETUP2_MASK = 8'h47;
	localparam logic [12:0] HOFF_RST    = 13'h0000;
	localparam logic [15:0] APIX_RST    = 16'h02D0;
	localparam logic [12:0] VOFF_RST    = 13'h0000;
	localparam logic [15:0] ALINE_RST   = 16'h00F0;
	localparam logic [15:0] ALINE_MAXLIT = 16'hFFFF;
	// image format codes in the low mode bits
	localparam logic [2:0] FMT_444  = 3'h0;
	localparam logic [2:0] FMT_422  = 3'h1;
	localparam logic [2:0] FMT_411H = 3'h2;
	localparam logic [2:0] FMT_411V = 3'h3;
	localparam logic [2:0] FMT_4444 = 3'h4;
	localparam logic [2:0] FMT_400  = 3'h5;
	// pixel to codec clock ratio codes
	localparam logic [1:0] RATIO_ONE     = 2'h0;
	localparam logic [1:0] RATIO_HALF    = 2'h1;
	localparam logic [1:0] RATIO_QUARTER = 2'h2;
	// line limits
	localparam logic [16:0] MAX_LINES  = 17'h10000;
	localparam logic [16:0] STRIP_MASK = 17'h00007;
endpackage

// *** core/pin_sync.sv ***
/*
 two-flop synchroniser for the two sync pins, with edge pulses.
 assumes the pins are asynchronous to mclk.
*/
`timescale 1ns/1ps
module pin_sync (
	input  wire logic       mclk,  // pixel clock
	input  wire logic       rstn,  // async reset, low
	input  wire logic [1:0] pins,  // raw pins
	output logic      [1:0] rise,  // rising edge pulse
	output logic      [1:0] fall   // falling edge pulse
);
	typedef struct packed {
		logic [1:0] s1;  // first stage, read by s2 only
		logic [1:0] s2;  // stable level
		logic [1:0] s3;  // previous level
	} sync_s;

	sync_s q;  // state
	sync_s n;  // next state

	// shift chain
	always_comb begin
		n    = q;
		n.s1 = pins;
		n.s2 = q.s1;
		n.s3 = q.s2;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// edges use only the settled stages
	assign rise = q.s2 & ~q.s3;
	assign fall = ~q.s2 & q.s3;
endmodule

// *** core/line_counter.sv ***
/*
 per-frame line walker: skips offset lines, counts window lines.
 assumes edge pulses already synchronised to mclk.
*/
`timescale 1ns/1ps
module line_counter
	import window_regs_pkg::*;
(
	input  wire logic        mclk,        // pixel clock
	input  wire logic        rstn,        // async reset, low
	input  wire logic        vs_rise,     // frame start pulse
	input  wire logic        vs_fall,     // frame end pulse
	input  wire logic        hs_rise,     // line start pulse
	input  wire logic        arm,         // run enabled
	input  wire logic [12:0] half_height_scale_offset, // lines to skip
	input  wire logic [16:0] target,      // 0: until vsync falls
	input  wire logic        half_height, // drop even lines
	output logic             line_take,   // line processed pulse
	output logic             busy,        // frame in progress
	output logic             done,        // frame end pulse
	output logic      [16:0] lines_done   // processed lines
);
	typedef enum logic [1:0] {IDLE, OFFSET, ACTIVE} walk_e;
	typedef struct packed {
		walk_e       st;      // walker state
		logic [12:0] skip;    // offset lines seen
		logic [16:0] taken;   // window lines seen
		logic        parity;  // next line even
		logic        take;    // take pulse
		logic        done;    // end pulse
		logic [16:0] result;  // last frame count
		logic        busy;    // frame level, kept in a flop
	} walk_s;

	walk_s q;  // state
	walk_s n;  // next state

	// frame walk
	always_comb begin
		n      = q;
		n.take = 1'b0;
		n.done = 1'b0;
		case (q.st)
			IDLE: begin
				if (vs_rise && arm) begin
					n.skip   = '0;
					n.taken  = '0;
					n.parity = 1'b0;
					n.st     = (half_height_scale_offset == 13'h0000) ? ACTIVE : OFFSET;
				end
			end
			OFFSET: begin
				if (vs_fall) begin
					n.st     = IDLE;  // window never reached
					n.result = '0;
					n.done   = 1'b1;
				end else if (hs_rise) begin
					n.skip = q.skip + 13'h0001;
					if (n.skip == half_height_scale_offset) begin
						n.st = ACTIVE;
					end
				end
			end
			ACTIVE: begin
				if (vs_fall) begin
					// partial strip thrown away
					n.st     = IDLE;
					n.result = q.taken & ~STRIP_MASK;
					n.done   = 1'b1;
				end else if (hs_rise) begin
					n.taken  = q.taken + 17'h00001;
					n.parity = ~q.parity;
					n.take   = !(half_height && q.parity);
					// fixed count or hard cap ends the frame
					if ((n.taken == target) || (n.taken == MAX_LINES)) begin
						n.st     = IDLE;
						n.result = n.taken;
						n.done   = 1'b1;
					end
				end
			end
			default: begin
				n.st = IDLE;
			end
		endcase
		// registered copy so the busy output needs no decode after the flop
		n.busy = (n.st != IDLE);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			q <= '{st: IDLE, default: '0};
		end else begin
			q <= n;
		end
	end

	assign line_take  = q.take;
	assign busy       = q.busy;
	assign done       = q.done;
	assign lines_done = q.result;

	chk_drop_even: assert property (@(posedge mclk) disable iff (!rstn)
		(q.st == ACTIVE && !vs_fall && hs_rise && half_height && q.parity) |=> !q.take)
		else $error("even window line not dropped");
	chk_offset_gate: assert property (@(posedge mclk) disable iff (!rstn)
		q.take |-> $past(q.st) == ACTIVE && $past(q.skip) == half_height_scale_offset
			|| $past(half_height_scale_offset) == 13'h0000)
		else $error("line taken inside offset");
	chk_early_end: assert property (@(posedge mclk) disable iff (!rstn)
		(q.st != IDLE && vs_fall) |=> q.done && q.st == IDLE)
		else $error("frame not ended on vsync fall");
	chk_strip_floor: assert property (@(posedge mclk) disable iff (!rstn)
		($past(q.st) == ACTIVE && $past(vs_fall) && q.done) |-> (q.result & STRIP_MASK) == '0)
		else $error("partial strip counted");
	chk_line_cap: assert property (@(posedge mclk) disable iff (!rstn)
		q.taken <= MAX_LINES)
		else $error("more than 65536 lines taken");
endmodule

// *** tb/window_line_regs_bench.sv ***
/*
 self-checking bench for the window and line-count register bank.
 assumes the package and the design files are compiled ahead of it.
*/
`timescale 1ns/1ps
module window_line_regs_bench
	import window_regs_pkg::*;
;
	localparam logic [3:0] VER = 4'h5; // arbitrary version value
	logic        mclk;        // 25 MHz clock
	logic        rstn;        // async reset, low
	logic [7:0]  addr;        // direct address
	logic [7:0]  wr_data;     // write data
	logic        wr_en;       // write strobe
	logic        rd_en;       // read strobe
	logic [7:0]  rd_data;     // read data
	logic        vs;          // frame pin
	logic        hs;          // line pin
	logic        run_active;  // run bit
	logic        compress_select; // compress mode
	logic [1:0]  pixel_ratio; // clock ratio code
	logic        pixel_out_bus_on_codec_clk; // output bus clock pick
	logic        line_take;   // line pulse
	logic        frame_busy;  // frame level
	logic        frame_done;  // frame end pulse
	logic [7:0]  setup_one;   // setup byte one copy
	logic [7:0]  setup_two;   // setup byte two copy
	logic [7:0]  io_mode;     // mode byte copy
	logic [12:0] hoff;        // horizontal offset copy
	logic [15:0] apix;        // active pixel count copy
	logic [7:0]  d;           // last read byte
	int          n_errors;    // mismatches
	int          check_count; // comparisons
	int          n_take;      // line pulses seen
	int          n_done;      // frame ends seen

	window_line_regs #(.VERSION(VER)) dut (
		.mclk(mclk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .vertical_sync_in(vs),
		.horizontal_sync_in(hs), .run_active(run_active),
		.compress_select(compress_select), .setup_one(setup_one),
		.setup_two(setup_two), .io_mode(io_mode),
		.horiz_offset_pixels(hoff), .active_pixel_count(apix), .pixel_ratio(pixel_ratio),
		.pixel_out_bus_on_codec_clk(pixel_out_bus_on_codec_clk), .line_take(line_take),
		.frame_busy(frame_busy), .frame_done(frame_done)
	);

	////////////////////////////////////////////////////////////////////////
	// clock and pulse counting
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (line_take === 1'b1)
			n_take++;
		if (frame_done === 1'b1)
			n_done++;
	end

	////////////////////////////////////////////////////////////////////////
	// bus tasks and comparison
	task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask
	// pointer first, then the data port; pointer never steps
	task automatic iwr(input logic [7:0] p, input logic [7:0] v);
		wr(DIR_PTR, p);
		wr(DIR_DATA, v);
	endtask
	task automatic ird(input logic [7:0] p);
		wr(DIR_PTR, p);
		rd(DIR_DATA);
	endtask
	task automatic settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask
	// one frame: hsync pulses inside vsync, then wait out the walker
	task automatic frame(input int lines);
		n_take = 0;
		n_done = 0;
		@(posedge mclk);
		vs <= 1'b1;
		repeat (6) @(posedge mclk);
		repeat (lines) begin
			hs <= 1'b1;
			repeat (4) @(posedge mclk);
			hs <= 1'b0;
			repeat (4) @(posedge mclk);
		end
		vs <= 1'b0;
		for (int i = 0; i < 60 && frame_busy !== 1'b0; i++)
			@(posedge mclk);
		#1 chk("frame_busy", 17'h0, {16'h0, frame_busy});
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		ird(IND_VOFF_HI); chk("voff_hi", 17'h00, {9'h0, d});
		ird(IND_ALINE_LO); chk("aline_lo", 17'hF0, {9'h0, d});
		ird(IND_ALINE_HI); chk("aline_hi", 17'h00, {9'h0, d});
		ird(IND_PROC_LO); chk("proc_lo", 17'hF0, {9'h0, d});
		ird(IND_PROC_HI); chk("proc_hi", 17'h00, {9'h0, d});
		chk("compress", 17'h1, {16'h0, compress_select});
		chk("setup_one", {9'h0, SETUP1_RST}, {9'h0, setup_one});
		chk("setup_two", {9'h0, SETUP2_RST}, {9'h0, setup_two});
		chk("io_mode", {9'h0, MODE_RST}, {9'h0, io_mode});
		chk("hoff", {4'h0, HOFF_RST}, {4'h0, hoff});
		chk("apix", {1'b0, APIX_RST}, {1'b0, apix});
		rd(DIR_RUN); chk("run_reg", {9'h0, VER, 4'h0}, {9'h0, d});
	endtask
	task automatic t_regs();
		iwr(IND_VOFF_HI, 8'hFF);
		ird(IND_VOFF_HI); chk("voff_hi", 17'h1F, {9'h0, d});
		iwr(IND_PROC_LO, 8'h55);
		ird(IND_PROC_LO); chk("proc_ro", 17'hF0, {9'h0, d});
		wr(DIR_RUN, 8'hF1);
		rd(DIR_RUN); chk("run_reg", {9'h0, VER, 4'h1}, {9'h0, d});
		chk("run_active", 17'h1, {16'h0, run_active});
		rd(8'h04); chk("unmapped", 17'h00, {9'h0, d});
		// reserved bits of setup two must not stick
		iwr(IND_SETUP2, 8'hFF);
		settle();
		chk("setup_two", 17'h47, {9'h0, setup_two});
		iwr(IND_SETUP2, 8'h00);
		iwr(IND_VOFF_HI, 8'h00);
	endtask
	task automatic t_window();
		iwr(IND_VOFF_LO, 8'h01);
		iwr(IND_ALINE_LO, 8'h02);
		frame(4); // one skipped, two taken, the last ignored
		chk("takes", 17'd2, n_take[16:0]);
		chk("dones", 17'd1, n_done[16:0]);
		ird(IND_PROC_LO); chk("proc_lo", 17'h02, {9'h0, d});
		chk("run_seq", 17'h1, {16'h0, run_active});
	endtask
	task automatic t_free();
		iwr(IND_VOFF_LO, 8'h00);
		iwr(IND_ALINE_LO, 8'h00);
		frame(11); // three lines past the first strip
		ird(IND_PROC_LO); chk("proc_lo", 17'h08, {9'h0, d});
		ird(IND_PROC_HI); chk("proc_hi", 17'h00, {9'h0, d});
	endtask
	task automatic t_ratio();
		wr(DIR_MODE, 8'h85); settle();
		chk("ratio_400", {15'h0, RATIO_ONE}, {15'h0, pixel_ratio});
		chk("pixel_out_bus_clk", 17'h1, {16'h0, pixel_out_bus_on_codec_clk});
		wr(DIR_MODE, 8'h81);
		iwr(IND_SETUP1, 8'h21); settle();
		chk("ratio_hw", {15'h0, RATIO_HALF}, {15'h0, pixel_ratio});
		chk("pixel_out_bus_clk", 17'h0, {16'h0, pixel_out_bus_on_codec_clk});
		iwr(IND_SETUP1, 8'hA1); settle();
		chk("ratio_slow", {15'h0, RATIO_ONE}, {15'h0, pixel_ratio});
		// full colour with slow codec clock goes from a quarter to a half
		wr(DIR_MODE, 8'h80);
		settle();
		chk("ratio_444slow", {15'h0, RATIO_HALF}, {15'h0, pixel_ratio});
		wr(DIR_MODE, 8'h00); settle();
		chk("expand", 17'h0, {16'h0, compress_select});
		wr(DIR_MODE, 8'h80);
		iwr(IND_SETUP1, 8'h01);
	endtask
	task automatic t_single();
		iwr(IND_SETUP1, 8'h40);
		iwr(IND_ALINE_LO, 8'h04); // even count with half height
		frame(6); // second and fourth window lines dropped
		chk("takes_hh", 17'd2, n_take[16:0]);
		chk("run_single", 17'h0, {16'h0, run_active});
		// expansion frame walks the window but leaves the counter alone
		wr(DIR_MODE, 8'h00);
		wr(DIR_RUN, 8'h01);
		iwr(IND_ALINE_LO, 8'h02); // even count with half height
		frame(6);
		chk("run_exp", 17'h0, {16'h0, run_active});
		ird(IND_PROC_LO); chk("proc_exp", 17'h04, {9'h0, d});
	endtask

	////////////////////////////////////////////////////////////////////////
	// verdict, watchdog and main sequence
	task automatic results();
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		results();
	end
	initial begin
		{rstn, wr_en, rd_en, vs, hs} = 5'h00;
		addr = 8'h00;
		wr_data = 8'h00;
		n_errors = 0;
		check_count = 0;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		t_reset();
		t_regs();
		t_window();
		t_free();
		t_ratio();
		t_single();
		results();
	end
endmodule
